/* File: regulator_ctrl_map.svh */
`ifndef REGULATOR_CTRL_MAP_SVH
`define REGULATOR_CTRL_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL_OFFSET 12'h000
`define REG_SRC_OFFSET 12'h004

// ----------------------------------------
// field positions
// ----------------------------------------
`define REG_OFF_BIT 7
`define REG_VBUS_STAT_BIT 6
`define REG_VBUS_POL_BIT 5
`define REG_LOWPWR_BIT 4
`define REG_VBUS_IEN_BIT 0
`define REG_USB_RST_SRC_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define REG_CTRL_RESET 8'h00
`define REG_SRC_RESET 2'h0

// ----------------------------------------
// per-field reset values
// ----------------------------------------
`define REG_OFF_RESET 1'b0
`define REG_POL_RESET 1'b0
`define REG_LOWPWR_RESET 1'b0
`define REG_VBUS_IEN_RESET 1'b0
`define REG_USB_RST_SRC_RESET 1'b0
`define REG_SYNC_IDLE 1'b0

`endif

/* File: regulator_ctrl_pkg.sv */
package regulator_ctrl_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic regulator_off;
    logic low_power;
  } regulator_drive_t;

endpackage

/* File: regulator_ctrl_vbus_detect.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "regulator_ctrl_map.svh"

// Function
// RULE1 - software switches the supply regulator on or off with one control bit
// RULE2 - low-power select bit puts the regulator in suspend low-power mode
// RULE3 - status bit shows the live bus-power level, not latched
// RULE4 - enabled interrupt asserts while bus power equals chosen polarity
// RULE5 - interrupt is level-sensitive with no pending flag to clear
// RULE6 - usb reset source enabled gives system reset while bus power matches polarity
// RULE7 - regulator off is control bit 7; 1 disables, 0 enables
// RULE8 - bus-power status is read-only bit 6, 1 when present
// RULE9 - polarity select is bit 5; 0 active low, 1 active high
// RULE10 - low-power select is bit 4; all fields reset to zero
// RULE11 - bus-power input is synchronised before status, interrupt and reset use
module regulator_ctrl_vbus_detect (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire regulator_ctrl_pkg::apb_req_t apb_req_in,
  output regulator_ctrl_pkg::apb_rsp_t apb_rsp_out,
  input wire logic bus_power_in,
  output regulator_ctrl_pkg::regulator_drive_t regulator_out,
  output logic bus_power_irq_out,
  output logic usb_reset_req_out
);
  import regulator_ctrl_pkg::*;

  // ----------------------------------------
  // synchroniser state
  // ----------------------------------------
  logic vbus_meta_q;
  logic vbus_sync_q;
  logic level_match;

  // ----------------------------------------
  // control and source fields
  // ----------------------------------------
  logic off_q;
  logic polarity_q;
  logic low_power_q;
  logic irq_en_q;
  logic rst_src_en_q;

  // ----------------------------------------
  // bus decode nets
  // ----------------------------------------
  logic setup_phase;
  logic access_phase;
  logic ctrl_sel;
  logic src_sel;
  logic known_addr;
  logic wr_ctrl;
  logic wr_src;
  logic rd_capture;
  logic [7:0] ctrl_view;
  logic [1:0] src_view;
  logic [31:0] rdata_d;

  // ----------------------------------------
  // write data fields
  // ----------------------------------------
  logic wdata_off;
  logic wdata_polarity;
  logic wdata_low_power;
  logic wdata_irq_en;
  logic wdata_rst_src_en;

  // ----------------------------------------
  // response and output registers
  // ----------------------------------------
  logic pready_d;
  logic pslverr_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic regulator_off_q;
  logic low_power_out_q;
  logic irq_q;
  logic rst_req_q;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction

  function automatic logic level_matches(input logic level, input logic polarity);
    level_matches = (level == polarity);
  endfunction

  function automatic logic request_gate(input logic enable, input logic hit);
    request_gate = enable && hit;
  endfunction

  function automatic logic [7:0] pack_ctrl(input logic off, input logic status, input logic polarity,
    input logic low_power);
    pack_ctrl = `REG_CTRL_RESET;
    pack_ctrl[`REG_OFF_BIT] = off;
    pack_ctrl[`REG_VBUS_STAT_BIT] = status;
    pack_ctrl[`REG_VBUS_POL_BIT] = polarity;
    pack_ctrl[`REG_LOWPWR_BIT] = low_power;
  endfunction

  function automatic logic [1:0] pack_src(input logic irq_en, input logic rst_en);
    pack_src = `REG_SRC_RESET;
    pack_src[`REG_VBUS_IEN_BIT] = irq_en;
    pack_src[`REG_USB_RST_SRC_BIT] = rst_en;
  endfunction

  function automatic logic [31:0] widen_ctrl(input logic [7:0] v);
    widen_ctrl = {24'h0, v};
  endfunction

  function automatic logic [31:0] widen_src(input logic [1:0] v);
    widen_src = {30'h0, v};
  endfunction

  // ----------------------------------------
  // bus-power synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      vbus_meta_q <= `REG_SYNC_IDLE;
    end else begin
      vbus_meta_q <= bus_power_in; // RULE11
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      vbus_sync_q <= `REG_SYNC_IDLE;
    end else begin
      vbus_sync_q <= vbus_meta_q; // RULE11
    end
  end

  assign level_match = level_matches(vbus_sync_q, polarity_q); // RULE4 RULE9

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup_phase = apb_req_in.psel && !apb_req_in.penable;
  assign access_phase = apb_req_in.psel && apb_req_in.penable;
  assign ctrl_sel = addr_hit(apb_req_in.paddr, `REG_CTRL_OFFSET);
  assign src_sel = addr_hit(apb_req_in.paddr, `REG_SRC_OFFSET);
  assign known_addr = ctrl_sel || src_sel;
  assign wr_ctrl = access_phase && apb_req_in.pwrite && ctrl_sel;
  assign wr_src = access_phase && apb_req_in.pwrite && src_sel;
  assign rd_capture = setup_phase && !apb_req_in.pwrite;
  assign ctrl_view = pack_ctrl(off_q, vbus_sync_q, polarity_q, low_power_q); // RULE3 RULE8
  assign src_view = pack_src(irq_en_q, rst_src_en_q);

  // ----------------------------------------
  // write data extraction
  // ----------------------------------------
  assign wdata_off = apb_req_in.pwdata[`REG_OFF_BIT];
  assign wdata_polarity = apb_req_in.pwdata[`REG_VBUS_POL_BIT];
  assign wdata_low_power = apb_req_in.pwdata[`REG_LOWPWR_BIT];
  assign wdata_irq_en = apb_req_in.pwdata[`REG_VBUS_IEN_BIT];
  assign wdata_rst_src_en = apb_req_in.pwdata[`REG_USB_RST_SRC_BIT];

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (ctrl_sel) begin
      rdata_d = widen_ctrl(ctrl_view);
    end else if (src_sel) begin
      rdata_d = widen_src(src_view);
    end
  end

  // ----------------------------------------
  // regulator off field
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      off_q <= `REG_OFF_RESET; // RULE10
    end else if (wr_ctrl) begin
      off_q <= wdata_off; // RULE1 RULE7
    end
  end

  // ----------------------------------------
  // polarity field
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      polarity_q <= `REG_POL_RESET; // RULE10
    end else if (wr_ctrl) begin
      polarity_q <= wdata_polarity; // RULE9
    end
  end

  // ----------------------------------------
  // low-power field
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      low_power_q <= `REG_LOWPWR_RESET; // RULE10
    end else if (wr_ctrl) begin
      low_power_q <= wdata_low_power; // RULE2 RULE10
    end
  end

  // ----------------------------------------
  // interrupt enable field
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_en_q <= `REG_VBUS_IEN_RESET;
    end else if (wr_src) begin
      irq_en_q <= wdata_irq_en; // RULE4
    end
  end

  // ----------------------------------------
  // usb reset source field
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rst_src_en_q <= `REG_USB_RST_SRC_RESET;
    end else if (wr_src) begin
      rst_src_en_q <= wdata_rst_src_en; // RULE6
    end
  end

  // ----------------------------------------
  // apb response, registered from the setup phase, no wait state
  // ----------------------------------------
  assign pready_d = setup_phase;
  assign pslverr_d = setup_phase && !known_addr;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_capture) begin
      prdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // regulator drive
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      regulator_off_q <= `REG_OFF_RESET;
    end else begin
      regulator_off_q <= off_q; // RULE1 RULE7
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      low_power_out_q <= `REG_LOWPWR_RESET;
    end else begin
      low_power_out_q <= low_power_q; // RULE2
    end
  end

  // ----------------------------------------
  // bus-power interrupt request
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= request_gate(irq_en_q, level_match); // RULE4 RULE5
    end
  end

  // ----------------------------------------
  // usb reset request
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= request_gate(rst_src_en_q, level_match); // RULE6
    end
  end

  // ----------------------------------------
  // port drive
  // ----------------------------------------
  assign apb_rsp_out = '{pready: pready_q, pslverr: pslverr_q, prdata: prdata_q};
  assign regulator_out = '{regulator_off: regulator_off_q, low_power: low_power_out_q};
  assign bus_power_irq_out = irq_q;
  assign usb_reset_req_out = rst_req_q;

endmodule

/* File: reg_vbus_props.sv */
`timescale 1ns/100ps
module reg_vbus_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire regulator_ctrl_pkg::apb_req_t apb_req_in,
  input wire regulator_ctrl_pkg::apb_rsp_t apb_rsp_out,
  input wire logic bus_power_in,
  input wire regulator_ctrl_pkg::regulator_drive_t regulator_out,
  input wire logic bus_power_irq_out,
  input wire logic usb_reset_req_out
);
  import regulator_ctrl_pkg::*;
  wire xf = apb_req_in.psel & apb_req_in.penable & apb_rsp_out.pready;
  wire wr = xf & apb_req_in.pwrite & (apb_req_in.paddr == 12'h000);
  wire rd = xf & ~apb_req_in.pwrite & (apb_req_in.paddr == 12'h000);
  wire [31:0] wd = apb_req_in.pwdata;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ------
  // checks
  // ------
  off_wr_a: assert property (wr |-> ##2 regulator_out.regulator_off == $past(wd[7], 2)) else $error("off");
  lp_wr_a: assert property (wr |-> ##2 regulator_out.low_power == $past(wd[4], 2)) else $error("mode");
  drv_hold_a: assert property ($changed(regulator_out) |-> $past(wr, 2)) else $error("drive");
  stat_rd_a: assert property (rd |-> apb_rsp_out.prdata[6] == $past(bus_power_in, 3)) else $error("stat");
  sequence irq_held;
    $stable(bus_power_irq_out) [*2];
  endsequence
  sequence rst_held;
    $stable(usb_reset_req_out) [*2];
  endsequence
  sequence irq_steady;
    (bus_power_irq_out && $stable(bus_power_in) && !xf) [*4];
  endsequence
  sequence rst_steady;
    (usb_reset_req_out && $stable(bus_power_in) && !xf) [*4];
  endsequence
  irq_sync_a: assert property ($changed(bus_power_in) |=> irq_held) else $error("irq");
  rst_sync_a: assert property ($changed(bus_power_in) |=> rst_held) else $error("rst");
  irq_lvl_a: assert property (irq_steady |=> bus_power_irq_out) else $error("irq level");
  rst_lvl_a: assert property (rst_steady |=> usb_reset_req_out) else $error("rst level");
endmodule
bind regulator_ctrl_vbus_detect reg_vbus_props i_reg_vbus_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out), .bus_power_in(bus_power_in), .regulator_out(regulator_out),
  .bus_power_irq_out(bus_power_irq_out), .usb_reset_req_out(usb_reset_req_out));

/* File: bus_power_host.sv */
`timescale 1ns/100ps
module bus_power_host (
  input wire logic clk_sys_in,
  output logic bus_power_out
);
  initial bus_power_out = 1'b0;
  task automatic set_level(input logic v);
    @(posedge clk_sys_in);
    bus_power_out <= v;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import regulator_ctrl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  apb_req_t q = '0;
  apb_rsp_t r;
  regulator_drive_t ro;
  logic vb, irq, ur, er;
  logic [31:0] rd;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  bus_power_host i_bus_power_host (.clk_sys_in(clk_sys_in), .bus_power_out(vb));
  regulator_ctrl_vbus_detect i_regulator_ctrl_vbus_detect (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .apb_req_in(q), .apb_rsp_out(r), .bus_power_in(vb), .regulator_out(ro), .bus_power_irq_out(irq),
    .usb_reset_req_out(ur));
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    q <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys_in);
    q.penable <= 1'b1;
    do @(posedge clk_sys_in); while (r.pready !== 1'b1);
    rd = r.prdata;
    er = r.pslverr;
    q <= '0;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    xfer(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    xfer(1'b1, 12'h000, 32'hFF);
    xfer(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'hB0, rd);
    chk("drive", 32'h3, 32'(ro));
    xfer(1'b0, 12'h008, 32'h0);
    chk("unmapped", 32'h1, 32'(er));
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 12'h000, {24'h0, i[2], 1'b0, i[1], i[0], 4'h0});
      xfer(1'b1, 12'h004, i[2] ? 32'h2 : 32'h1);
      i_bus_power_host.set_level(i[0]);
      repeat (5) @(posedge clk_sys_in);
      chk("irq", 32'(!i[2] && i[0] == i[1]), 32'(irq));
      chk("usb reset", 32'(i[2] && i[0] == i[1]), 32'(ur));
      xfer(1'b0, 12'h000, 32'h0);
      chk("status", {24'h0, i[2], i[0], i[1], i[0], 4'h0}, rd);
      chk("off", 32'(i[2]), 32'(ro.regulator_off));
      chk("low power", 32'(i[0]), 32'(ro.low_power));
      xfer(1'b0, 12'h004, 32'h0);
      chk("source", i[2] ? 32'h2 : 32'h1, rd);
    end
    complete_run;
  end
endmodule
